/* src/rpvn_pkg.sv */
// package: constants and carrier types of the password-verify command block
// assumes: one 10 MHz clock, byte stream from a frame decoder upstream
package rpvn_pkg;
  localparam logic [7:0] CMD_WRITE = 8'h08;
  localparam logic [7:0] RSP_WRITE = 8'h09;
  localparam logic [7:0] SVC_MIN = 8'h01;
  localparam logic [7:0] SVC_MAX = 8'h0B;
  localparam logic [7:0] VERIFY_BLK_CNT = 8'h01;
  localparam logic [23:0] VERIFY_BLK_LIST = 24'h00_0001;
  localparam int BLOCK_BYTES = 16;
  localparam int ID_BYTES = 8;
  localparam int RSP_BYTES = 11;
  localparam logic [9:0] AIB_ADDR = 10'h000;
  localparam logic [9:0] FILE_ADDR = 10'h010;
  localparam logic [5:0] FILE_FIRST_BLK = 6'h01;
  localparam logic [5:0] FILE_LAST_BLK = 6'h3B;
  localparam logic [5:0] SYS_FIRST_BLK = 6'h3C;
  localparam logic [15:0] TYPE3_SYS_CODE = 16'h12FC;
  localparam logic [7:0] FLAG_OK = 8'h00;
  localparam logic [7:0] FLAG1_ERR = 8'hFF;
  localparam logic [7:0] FLAG2_SVC_CNT = 8'hA1;
  localparam logic [7:0] FLAG2_SVC_MIX = 8'hA2;
  localparam logic [7:0] FLAG2_BLK_CNT = 8'hA3;
  localparam logic [7:0] FLAG2_BLK_LIST = 8'hA4;
  localparam logic [7:0] FLAG2_LENGTH = 8'hA5;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rpvn_byte_s;

  typedef struct packed {
    logic [7:0] flag1;
    logic [7:0] flag2;
  } rpvn_status_s;

  typedef enum logic [3:0] {
    ST_CODE = 4'b0000,
    ST_ID = 4'b0001,
    ST_SVC_CNT = 4'b0010,
    ST_SVC_LIST = 4'b0011,
    ST_BLK_CNT = 4'b0100,
    ST_BLK_LIST = 4'b0101,
    ST_DATA = 4'b0110,
    ST_SKIP = 4'b0111,
    ST_RESP = 4'b1000
  } rpvn_state_e;
endpackage

/* src/rpvn_skid_buf.sv */
// two-entry buffer with valid/ready on both sides
// assumes: single clock, asynchronous active-high reset
module rpvn_skid_buf #(
  parameter int WIDTH = 9
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  logic [WIDTH-1:0] mem_reg [2];
  logic [WIDTH-1:0] mem_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;

  assign inReady = (cnt_reg != 2'd2);
  assign outValid = (cnt_reg != 2'd0);
  assign outData = mem_reg[rd_reg];

  always_comb begin
    logic push;
    logic pop;
    push = inValid && inReady;
    pop = outValid && outReady;
    mem_next = mem_reg;
    if (push) begin
      mem_next[wr_reg] = inData;
    end
    wr_next = push ? ~wr_reg : wr_reg;
    rd_next = pop ? ~rd_reg : rd_reg;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      cnt_reg <= 2'd0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
    end
  end

  full_empty_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(inReady == 1'b0 && outValid == 1'b0)) else $error("buffer full and empty at once");
endmodule

/* src/rpvn_mem_map.sv */
// address map of the tag-format user area
// assumes: block index tied to a constant by the command interpreter, 16 bytes per block
module rpvn_mem_map (
  input wire logic [5:0] blockIdx,
  input wire logic [15:0] sysCode,
  output logic [9:0] byteAddr,
  output logic isAttrBlock,
  output logic isFileBlock,
  output logic isSystemBlock,
  output logic type3Enabled
);
  always_comb begin
    byteAddr = {blockIdx, 4'h0};
    isAttrBlock = (byteAddr == rpvn_pkg::AIB_ADDR);
    isFileBlock = (blockIdx >= rpvn_pkg::FILE_FIRST_BLK)
      && (blockIdx <= rpvn_pkg::FILE_LAST_BLK);
    isSystemBlock = (blockIdx >= rpvn_pkg::SYS_FIRST_BLK);
    type3Enabled = (sysCode == rpvn_pkg::TYPE3_SYS_CODE);
  end
endmodule

/* src/rpvn_verify_cmd.sv */
// ---------------------------------------------------------------
// password-verify command interpreter
// ---------------------------------------------------------------
// holds: field checker, response sequencer, write-path constraint
// assumes: command bytes arrive framed with a last marker; the
// response leaves through a two-entry buffer toward the encoder
//
// Behaviour
// - code 0x08 shared with write command
// - service count outside 1..11 is error
// - service identifiers must all match
// - block count one, list 000001, 16 bytes
// - verify constrains the write command fields
// - answer 0x09, identifier, two flags, eleven bytes
// - tag-format exchange for type 3 and 4
// - attribute block lives at block zero
// - data file occupies blocks one to fifty-nine
module rpvn_verify_cmd #(
  parameter logic [63:0] CARD_ID = 64'h0123_4567_89AB_CDEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] cmdData,
  input wire logic cmdLast,
  input wire logic cmdValid,
  output logic cmdReady,
  output logic [7:0] rspData,
  output logic rspLast,
  output logic rspValid,
  input wire logic rspReady,
  input wire logic [15:0] sysCode,
  output logic verifyDone,
  output logic verifyPassed,
  output logic [127:0] password,
  output logic type3Enabled,
  output logic [9:0] attrAddr,
  output logic [9:0] fileAddr
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rpvn_pkg::rpvn_state_e state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] svcCnt_reg, svcCnt_next;
  logic [15:0] svcFirst_reg, svcFirst_next;
  logic [7:0] svcLo_reg, svcLo_next;
  logic [23:0] blkList_reg, blkList_next;
  logic [127:0] pwd_reg, pwd_next;
  rpvn_pkg::rpvn_status_s status_reg, status_next;
  logic done_reg, done_next;
  logic pass_reg, pass_next;
  logic [7:0] bufInData;
  logic bufInLast;
  logic bufInValid;
  logic bufInReady;
  logic take;
  logic [63:0] idShift;
  logic attrIsAttr, attrIsFile, attrIsSys;
  logic fileIsAttr, fileIsFile, fileIsSys;

  assign take = cmdValid && cmdReady;
  assign cmdReady = (state_reg != rpvn_pkg::ST_RESP);
  assign verifyDone = done_reg;
  assign verifyPassed = pass_reg;
  assign password = pwd_reg;
  // answer byte 1 carries the top identifier byte, so count from zero there
  assign idShift = CARD_ID << {3'(cnt_reg[2:0] - 3'd1), 3'b000};

  // ---------------------------------------------------------------
  // command parser and response sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    svcCnt_next = svcCnt_reg;
    svcFirst_next = svcFirst_reg;
    svcLo_next = svcLo_reg;
    blkList_next = blkList_reg;
    pwd_next = pwd_reg;
    status_next = status_reg;
    done_next = 1'b0;
    pass_next = pass_reg;
    bufInData = 8'h00;
    bufInLast = 1'b0;
    bufInValid = 1'b0;
    case (state_reg)
      rpvn_pkg::ST_CODE: begin
        if (take) begin
          cnt_next = 5'd0;
          status_next = '{flag1: rpvn_pkg::FLAG_OK, flag2: rpvn_pkg::FLAG_OK};
          // other codes are not this block's; drop the frame
          state_next = (cmdData == rpvn_pkg::CMD_WRITE) ? rpvn_pkg::ST_ID
            : rpvn_pkg::ST_SKIP;
        end
      end
      rpvn_pkg::ST_ID: begin
        // identifier content is the reader's duty, not checked here
        if (take) begin
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'(rpvn_pkg::ID_BYTES - 1)) begin
            cnt_next = 5'd0;
            state_next = rpvn_pkg::ST_SVC_CNT;
          end
        end
      end
      rpvn_pkg::ST_SVC_CNT: begin
        if (take) begin
          svcCnt_next = cmdData;
          if (cmdData < rpvn_pkg::SVC_MIN || cmdData > rpvn_pkg::SVC_MAX) begin
            status_next = '{flag1: rpvn_pkg::FLAG1_ERR, flag2: rpvn_pkg::FLAG2_SVC_CNT};
            state_next = rpvn_pkg::ST_SKIP;
          end else begin
            state_next = rpvn_pkg::ST_SVC_LIST;
          end
        end
      end
      rpvn_pkg::ST_SVC_LIST: begin
        if (take) begin
          cnt_next = cnt_reg + 5'd1;
          if (!cnt_reg[0]) begin
            svcLo_next = cmdData;
          end else if (cnt_reg == 5'd1) begin
            svcFirst_next = {svcLo_reg, cmdData};
          end else if ({svcLo_reg, cmdData} != svcFirst_reg
            && status_reg.flag1 == rpvn_pkg::FLAG_OK) begin
            status_next = '{flag1: rpvn_pkg::FLAG1_ERR, flag2: rpvn_pkg::FLAG2_SVC_MIX};
          end
          if (cnt_reg == 5'({svcCnt_reg[3:0], 1'b0} - 5'd1)) begin
            state_next = rpvn_pkg::ST_BLK_CNT;
          end
        end
      end
      rpvn_pkg::ST_BLK_CNT: begin
        if (take) begin
          cnt_next = 5'd0;
          if (cmdData != rpvn_pkg::VERIFY_BLK_CNT) begin
            status_next = '{flag1: rpvn_pkg::FLAG1_ERR, flag2: rpvn_pkg::FLAG2_BLK_CNT};
            state_next = rpvn_pkg::ST_SKIP;
          end else begin
            state_next = rpvn_pkg::ST_BLK_LIST;
          end
        end
      end
      rpvn_pkg::ST_BLK_LIST: begin
        if (take) begin
          blkList_next = {blkList_reg[15:0], cmdData};
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'd2) begin
            cnt_next = 5'd0;
            if ({blkList_reg[15:0], cmdData} != rpvn_pkg::VERIFY_BLK_LIST) begin
              status_next = '{flag1: rpvn_pkg::FLAG1_ERR, flag2: rpvn_pkg::FLAG2_BLK_LIST};
              state_next = rpvn_pkg::ST_SKIP;
            end else begin
              state_next = rpvn_pkg::ST_DATA;
            end
          end
        end
      end
      rpvn_pkg::ST_DATA: begin
        if (take) begin
          pwd_next = {pwd_reg[119:0], cmdData};
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'(rpvn_pkg::BLOCK_BYTES - 1)) begin
            cnt_next = 5'd0;
            state_next = cmdLast ? rpvn_pkg::ST_RESP : rpvn_pkg::ST_SKIP;
            if (!cmdLast) begin
              status_next = '{flag1: rpvn_pkg::FLAG1_ERR, flag2: rpvn_pkg::FLAG2_LENGTH};
            end
          end else if (cmdLast) begin
            // short block: the frame is over, nothing left to drain
            cnt_next = 5'd0;
            status_next = '{flag1: rpvn_pkg::FLAG1_ERR, flag2: rpvn_pkg::FLAG2_LENGTH};
            state_next = rpvn_pkg::ST_RESP;
          end
        end
      end
      rpvn_pkg::ST_SKIP: begin
        // a bad frame is drained to its end before any answer
        if (take && cmdLast) begin
          cnt_next = 5'd0;
          state_next = (status_reg.flag1 == rpvn_pkg::FLAG_OK)
            ? rpvn_pkg::ST_CODE : rpvn_pkg::ST_RESP;
        end
      end
      rpvn_pkg::ST_RESP: begin
        bufInValid = 1'b1;
        if (cnt_reg == 5'd0) begin
          bufInData = rpvn_pkg::RSP_WRITE;
        end else if (cnt_reg <= 5'(rpvn_pkg::ID_BYTES)) begin
          bufInData = idShift[63:56];
        end else if (cnt_reg == 5'(rpvn_pkg::ID_BYTES + 1)) begin
          bufInData = status_reg.flag1;
        end else begin
          bufInData = status_reg.flag2;
        end
        bufInLast = (cnt_reg == 5'(rpvn_pkg::RSP_BYTES - 1));
        if (bufInReady) begin
          cnt_next = cnt_reg + 5'd1;
          if (bufInLast) begin
            cnt_next = 5'd0;
            done_next = 1'b1;
            pass_next = (status_reg.flag1 == rpvn_pkg::FLAG_OK);
            state_next = rpvn_pkg::ST_CODE;
          end
        end
      end
      default: begin
        state_next = rpvn_pkg::ST_CODE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= rpvn_pkg::ST_CODE;
      cnt_reg <= 5'd0;
      svcCnt_reg <= 8'h00;
      svcFirst_reg <= 16'h0000;
      svcLo_reg <= 8'h00;
      blkList_reg <= 24'h00_0000;
      pwd_reg <= 128'h0;
      status_reg <= '0;
      done_reg <= 1'b0;
      pass_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      svcCnt_reg <= svcCnt_next;
      svcFirst_reg <= svcFirst_next;
      svcLo_reg <= svcLo_next;
      blkList_reg <= blkList_next;
      pwd_reg <= pwd_next;
      status_reg <= status_next;
      done_reg <= done_next;
      pass_reg <= pass_next;
    end
  end

  // ---------------------------------------------------------------
  // response buffer and memory map
  // ---------------------------------------------------------------
  rpvn_skid_buf #(.WIDTH(9)) rspBuf (
    .clk_sys(clk_sys),
    .rst(rst),
    .inData({bufInData, bufInLast}),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .outData({rspData, rspLast}),
    .outValid(rspValid),
    .outReady(rspReady)
  );

  // both tag types share the same user-area layout
  rpvn_mem_map attrMap (
    .blockIdx(6'h00),
    .sysCode(sysCode),
    .byteAddr(attrAddr),
    .isAttrBlock(attrIsAttr),
    .isFileBlock(attrIsFile),
    .isSystemBlock(attrIsSys),
    .type3Enabled(type3Enabled)
  );
  rpvn_mem_map fileMap (
    .blockIdx(rpvn_pkg::FILE_FIRST_BLK),
    .sysCode(sysCode),
    .byteAddr(fileAddr),
    .isAttrBlock(fileIsAttr),
    .isFileBlock(fileIsFile),
    .isSystemBlock(fileIsSys),
    .type3Enabled()
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  bad_code_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg == rpvn_pkg::ST_CODE && take && cmdData != rpvn_pkg::CMD_WRITE)
    |=> state_reg == rpvn_pkg::ST_SKIP) else $error("foreign code not skipped");
  svc_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg == rpvn_pkg::ST_SVC_CNT && take && (cmdData == 8'h00 || cmdData > 8'h0B))
    |=> status_reg.flag2 == rpvn_pkg::FLAG2_SVC_CNT) else $error("service count not flagged");
  svc_mix_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg == rpvn_pkg::ST_SVC_LIST && take && cnt_reg[0] && cnt_reg != 5'd1
    && {svcLo_reg, cmdData} != svcFirst_reg) |=> status_reg.flag1 == rpvn_pkg::FLAG1_ERR)
    else $error("mixed services not flagged");
  blk_cnt_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg == rpvn_pkg::ST_BLK_CNT && take && cmdData != 8'h01)
    |=> status_reg.flag2 == rpvn_pkg::FLAG2_BLK_CNT) else $error("block count not flagged");
  rsp_code_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg == rpvn_pkg::ST_RESP && cnt_reg == 5'd0) |-> bufInData == 8'h09)
    else $error("wrong response code");
  rsp_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    (bufInValid && bufInLast) |-> cnt_reg == 5'd10) else $error("response not eleven bytes");
  err_pass_a: assert property (@(posedge clk_sys) disable iff (rst)
    (done_reg && status_reg.flag1 != rpvn_pkg::FLAG_OK) |-> !pass_reg)
    else $error("error reported as pass");
  no_take_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == rpvn_pkg::ST_RESP |-> !cmdReady) else $error("command taken while answering");
  map_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
    attrAddr == 10'h000 && fileAddr == 10'h010) else $error("map addresses wrong");
  map_kinds_a: assert property (@(posedge clk_sys) disable iff (rst)
    attrIsAttr && !attrIsFile && !attrIsSys && !fileIsAttr && fileIsFile && !fileIsSys)
    else $error("map block kinds wrong");
  short_data_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg == rpvn_pkg::ST_DATA && take && cmdLast && cnt_reg != 5'd15)
    |=> state_reg == rpvn_pkg::ST_RESP && status_reg.flag2 == rpvn_pkg::FLAG2_LENGTH)
    else $error("short block not answered");
endmodule

/* tb/rpvn_reader_model.sv */
// reader model: sends command frames byte by byte, gathers answer bytes
// assumes: bench sets stallMode; all drives land on the falling edge
module rpvn_reader_model (
  input wire logic clk_sys,
  input wire logic rst,
  output logic [7:0] cmdData,
  output logic cmdLast,
  output logic cmdValid,
  input wire logic cmdReady,
  input wire logic [7:0] rspData,
  input wire logic rspLast,
  input wire logic rspValid,
  output logic rspReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rxQ[$];
  logic rxLast[$];
  int stallMode = 0;
  int cyc = 0;
  initial begin
    cmdData = 8'h00;
    cmdLast = 1'b0;
    cmdValid = 1'b0;
    rspReady = 1'b0;
  end
  // ----------------------------------------
  // command side
  // ----------------------------------------
  task automatic sendFrame(input logic [7:0] frame[$], output bit ok);
    int n;
    ok = 1'b1;
    foreach (frame[i]) begin
      @(negedge clk_sys);
      cmdData <= frame[i];
      cmdLast <= (i == frame.size() - 1);
      cmdValid <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (cmdReady !== 1'b1 && n < 100);
      if (n >= 100) ok = 1'b0;
    end
    @(negedge clk_sys);
    cmdValid <= 1'b0;
    cmdLast <= 1'b0;
    cmdData <= ~cmdData;  // idle bus never shows the last byte
  endtask
  // ----------------------------------------
  // answer side
  // ----------------------------------------
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    // slow mode stalls two cycles of three, filling the buffer
    rspReady <= (stallMode == 0) || (cyc % 3 == 0);
  end
  always @(posedge clk_sys) begin
    if (rspValid === 1'b1 && rspReady === 1'b1) begin
      rxQ.push_back(rspData);
      rxLast.push_back(rspLast);
    end
  end
endmodule

/* tb/rpvn_verify_cmd_bench.sv */
// bench: verify command frames against the interpreter and its memory map
// assumes: reader model on the command side, no other parties
module rpvn_verify_cmd_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] TB_ID = 64'hA5C3_0F1E_2D3C_4B5A;  // arbitrary value
  logic clk_sys = 1'b0;
  logic rst;
  logic [7:0] cmdData, rspData;
  logic cmdLast, cmdValid, cmdReady, rspLast, rspValid, rspReady;
  logic [15:0] sysCode;
  logic verifyDone, verifyPassed, type3Enabled;
  logic [127:0] password;
  logic [9:0] attrAddr, fileAddr;
  int fails = 0;
  int tests_run = 0;
  int doneCount = 0;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (verifyDone === 1'b1) doneCount++;
  end
  rpvn_reader_model reader (.clk_sys(clk_sys), .rst(rst), .cmdData(cmdData),
    .cmdLast(cmdLast), .cmdValid(cmdValid), .cmdReady(cmdReady), .rspData(rspData),
    .rspLast(rspLast), .rspValid(rspValid), .rspReady(rspReady));
  rpvn_verify_cmd #(.CARD_ID(TB_ID)) dut (.clk_sys(clk_sys), .rst(rst),
    .cmdData(cmdData), .cmdLast(cmdLast), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .rspData(rspData), .rspLast(rspLast), .rspValid(rspValid), .rspReady(rspReady),
    .sysCode(sysCode), .verifyDone(verifyDone), .verifyPassed(verifyPassed),
    .password(password), .type3Enabled(type3Enabled), .attrAddr(attrAddr),
    .fileAddr(fileAddr));
  // attribute block image: progress flag at byte 9, checksum in the last two
  function automatic logic [127:0] attrImage(input logic [7:0] progress);
    logic [127:0] img;
    logic [15:0] sum;
    img = {8'h10, 8'h0F, 8'h0B, 16'h0018, 32'h0000_0000, progress, 8'h01, 24'h00_0003,
      16'h0000};
    sum = 16'h0000;
    for (int i = 0; i < 14; i++) sum += 16'(img[127 - 8 * i -: 8]);
    img[15:0] = sum;
    return img;
  endfunction
  // ----------------------------------------
  // checking and verdict
  // ----------------------------------------
  task automatic cmpVec(input string nm, input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmpBit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // one frame out, answer in, judged
  // ----------------------------------------
  task automatic runVerify(input logic [7:0] code = rpvn_pkg::CMD_WRITE, input int k = 1,
      input bit mix = 0, input logic [7:0] m = rpvn_pkg::VERIFY_BLK_CNT,
      input logic [23:0] list = rpvn_pkg::VERIFY_BLK_LIST, input int nData = 16,
      input logic [7:0] ex = rpvn_pkg::FLAG_OK, input bit expResp = 1,
      input logic [127:0] blk = 128'h4041_4243_4445_4647_4849_4A4B_4C4D_4E4F);
    logic [7:0] f[$];
    logic [127:0] pw;
    bit ok;
    int n;
    int d0;
    pw = '0;
    d0 = doneCount;
    f = {code};
    for (int i = 0; i < 8; i++) f.push_back(TB_ID[63 - 8 * i -: 8]);
    f.push_back(k[7:0]);
    for (int i = 0; i < k; i++) begin
      f.push_back(8'h09);
      f.push_back((mix && i == k - 1) ? 8'h01 : 8'h00);
    end
    f.push_back(m);
    f.push_back(list[23:16]);
    f.push_back(list[15:8]);
    f.push_back(list[7:0]);
    for (int i = 0; i < nData; i++) begin
      f.push_back(blk[127 - 8 * i -: 8]);
      pw = {pw[119:0], blk[127 - 8 * i -: 8]};
    end
    reader.rxQ.delete();
    reader.rxLast.delete();
    reader.sendFrame(f, ok);
    n = 0;
    while (reader.rxQ.size() < 11 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    // a stuck handshake or missing answer ends the run
    if (!ok || (expResp && n >= 100)) begin
      fails++;
      results();
    end
    if (!expResp) begin
      cmpVec("answer bytes", 0, 128'(reader.rxQ.size()));
      return;
    end
    cmpVec("answer bytes", 11, 128'(reader.rxQ.size()));
    cmpVec("code", rpvn_pkg::RSP_WRITE, reader.rxQ[0]);
    for (int i = 0; i < 8; i++) cmpVec("identifier", TB_ID[63 - 8 * i -: 8], reader.rxQ[1 + i]);
    cmpVec("flag1", (ex == rpvn_pkg::FLAG_OK) ? ex : rpvn_pkg::FLAG1_ERR, reader.rxQ[9]);
    cmpVec("flag2", ex, reader.rxQ[10]);
    for (int i = 0; i < 11; i++) cmpBit("last", i == 10, reader.rxLast[i]);
    cmpVec("done pulses", 128'(d0 + 1), 128'(doneCount));
    cmpBit("passed", ex == rpvn_pkg::FLAG_OK, verifyPassed);
    if (ex == rpvn_pkg::FLAG_OK) cmpVec("password", pw, password);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic scenGood();
    runVerify(.blk(attrImage(8'h0F)));
  endtask
  task automatic scenSlowPair();
    reader.stallMode = 1;
    runVerify(.k(2));
    reader.stallMode = 0;
  endtask
  task automatic scenSvcRange();
    int ks[4] = '{0, 11, 12, 15};
    logic [7:0] xs[4] = '{8'hA1, 8'h00, 8'hA1, 8'hA1};
    foreach (ks[i]) runVerify(.k(ks[i]), .ex(xs[i]));
  endtask
  task automatic scenFields();
    runVerify(.k(3), .mix(1), .ex(rpvn_pkg::FLAG2_SVC_MIX));
    runVerify(.m(8'h02), .ex(rpvn_pkg::FLAG2_BLK_CNT));
    runVerify(.list(24'h00_0002), .ex(rpvn_pkg::FLAG2_BLK_LIST));
    runVerify(.nData(15), .ex(rpvn_pkg::FLAG2_LENGTH));
    runVerify(.code(8'h07), .expResp(0));
    runVerify(.blk(attrImage(8'h00)));
  endtask
  task automatic scenMap();
    logic [15:0] codes[5] = '{16'h12FD, rpvn_pkg::TYPE3_SYS_CODE, 16'h0000, 16'hFFFF,
      16'h02FC};
    foreach (codes[i]) begin
      @(negedge clk_sys);
      sysCode = codes[i];
      @(posedge clk_sys);
      cmpBit("type3", codes[i] == rpvn_pkg::TYPE3_SYS_CODE, type3Enabled);
      cmpVec("attr address", 10'h000, attrAddr);
      cmpVec("file address", 10'h010, fileAddr);
      cmpBit("attr block", 1'b1, dut.attrIsAttr);
      cmpBit("file block", 1'b1, dut.fileIsFile);
      cmpBit("system block", 1'b0, dut.fileIsSys);
    end
  endtask
  initial begin
    rst = 1'b1;
    sysCode = rpvn_pkg::TYPE3_SYS_CODE;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    cmpBit("idle valid", 1'b0, rspValid);
    cmpBit("idle ready", 1'b1, cmdReady);
    scenGood();
    scenSlowPair();
    scenSvcRange();
    scenFields();
    scenMap();
    results();
  end
endmodule
